// File: common/rtz_pkg.sv
// Constants and state layout for the timer zero control block
package rtz_pkg;
  // Register indices; word address on the bus equals the index
  localparam logic [5:0] RTZ_IDX_RUN_CTRL  = 6'h0E;
  localparam logic [5:0] RTZ_IDX_CONFIG    = 6'h0F;
  localparam logic [5:0] RTZ_IDX_RELOAD_HI = 6'h10;
  localparam logic [5:0] RTZ_IDX_RELOAD_LO = 6'h11;
  localparam logic [5:0] RTZ_IDX_COUNT_HI  = 6'h12;
  localparam logic [5:0] RTZ_IDX_COUNT_LO  = 6'h13;
  localparam logic [5:0] RTZ_IDX_IRQ_STAT  = 6'h20;
  localparam logic [5:0] RTZ_IDX_IRQ_CLEAR = 6'h21;
  localparam logic [5:0] RTZ_IDX_IRQ_EN    = 6'h22;

  // Run control layout
  localparam int RTZ_RUN_LSB  = 4;
  localparam int RTZ_MASK_LSB = 0;
  localparam int RTZ_TIMERS   = 4;

  // Config layout
  localparam int RTZ_CFG_STOP_RX = 7;
  localparam int RTZ_CFG_MODE_HI = 5;
  localparam int RTZ_CFG_MODE_LO = 4;
  localparam int RTZ_CFG_RESTART = 3;
  localparam int RTZ_CFG_CLK_HI  = 1;
  localparam int RTZ_CFG_CLK_LO  = 0;
  localparam logic [7:0] RTZ_CFG_WMASK = 8'hBB;

  // Start modes
  localparam logic [1:0] RTZ_MODE_MANUAL = 2'h0;
  localparam logic [1:0] RTZ_MODE_TX_END = 2'h1;
  localparam logic [1:0] RTZ_MODE_LFO_NU = 2'h2;
  localparam logic [1:0] RTZ_MODE_LFO_UF = 2'h3;

  // Count clock selections
  localparam logic [1:0] RTZ_CLK_CARRIER = 2'h0;
  localparam logic [1:0] RTZ_CLK_DIVIDED = 2'h1;
  localparam logic [1:0] RTZ_CLK_T2_UF   = 2'h2;
  localparam logic [1:0] RTZ_CLK_T1_UF   = 2'h3;

  // Interrupt status bits
  localparam int RTZ_IRQ_UNDERFLOW = 0;
  localparam int RTZ_IRQ_RX_HALT   = 1;

  // Reset values
  localparam logic [7:0]  RTZ_RST_BYTE  = 8'h00;
  localparam logic [15:0] RTZ_RST_COUNT = 16'h0000;
  localparam logic [31:0] RTZ_RST_WORD  = 32'h0000_0000;

  // Bus answer latency in cycles after the request is first seen
  localparam int RTZ_BUS_LATENCY = 1;

  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
    logic [3:0]  active;
    logic [7:0]  cfg;
    logic [7:0]  rel_hi;
    logic [7:0]  rel_lo;
    logic [15:0] cnt;
    logic [1:0]  status;
    logic [1:0]  enable;
    logic        irq;
    logic        und;
  } rtz_state_t;
endpackage

// File: logic/rtz_timer_zero.sv
// Timer zero with shared run control and an Avalon-MM register slave
// Functional notes
// - Low four mask bits let a write change the matching running bit
// - Bits seven to four read back running state of timers three..zero
// - Masked running bit written one starts a timer, zero stops it
// - Stop-on-receive halts timer zero after the first four received bits
// - Stop-on-receive has no effect in oscillator trimming modes
// - Start mode 00 no auto start, 01 start at end of transmission
// - Modes 10/11 trim oscillator, edges toggle run; 11 allows underflow
// - Auto-restart set: reload and keep counting at each underflow
// - Auto-restart clear: count to zero, then stop
// - Underflow sets the timer interrupt flag
// - Clock select 00 carrier tick, 01 divided tick
// - Clock select 10 timer two underflow, 11 timer one underflow
// - Start event loads both reload bytes into the counter
// - Reload writes do not disturb a running count
// - Registers at indices 0E, 0F, 10 and 11
// - Current count readable as high and low bytes
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
module rtz_timer_zero (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Count clock ticks and cascade inputs
  input  wire logic        i_tick_carrier,
  input  wire logic        i_tick_divided,
  input  wire logic        i_timer_two_underflow,
  input  wire logic        i_timer_one_underflow,
  // Link events
  input  wire logic        i_tx_done,
  input  wire logic        i_rx_first_bits,
  input  wire logic        i_lfo_edge,
  // Status outputs
  output logic [rtz_pkg::RTZ_TIMERS-1:0] o_timer_active,
  output logic             o_timer_zero_underflow,
  output logic             o_irq
);
  import rtz_pkg::*;

  rtz_state_t s;
  rtz_state_t n;

  logic       take;
  logic       ack;
  logic       ack_wr;
  logic       ack_rd;
  logic       sw_run_wr;
  logic       tick;
  logic       lfo_mode;
  logic [1:0] mode;
  logic       rx_halt;
  logic [15:0] reload;

  assign take      = s.wreq & (i_avs_read | i_avs_write);
  assign ack       = ~s.wreq & (i_avs_read | i_avs_write);
  assign ack_wr    = ack & i_avs_write & i_avs_byteenable[0];
  assign ack_rd    = ack & i_avs_read;
  assign sw_run_wr = ack_wr & (i_avs_address == RTZ_IDX_RUN_CTRL);
  assign mode      = s.cfg[RTZ_CFG_MODE_HI:RTZ_CFG_MODE_LO];
  assign lfo_mode  = s.cfg[RTZ_CFG_MODE_HI];
  assign reload    = {s.rel_hi, s.rel_lo};
  assign rx_halt   = s.active[0] & s.cfg[RTZ_CFG_STOP_RX] & ~lfo_mode
                     & i_rx_first_bits;

  // Count clock selection
  always_comb begin
    case (s.cfg[RTZ_CFG_CLK_HI:RTZ_CFG_CLK_LO])
      RTZ_CLK_CARRIER: tick = i_tick_carrier;
      RTZ_CLK_DIVIDED: tick = i_tick_divided;
      RTZ_CLK_T2_UF:   tick = i_timer_two_underflow;
      RTZ_CLK_T1_UF:   tick = i_timer_one_underflow;
      default:         tick = 1'b0;
    endcase
  end

  always_comb begin
    n     = s;
    n.und = 1'b0;

    // Bus handshake: one wait cycle, then answer
    if (take) begin
      n.wreq  = 1'b0;
      n.rdata = RTZ_RST_WORD;
      if (i_avs_read) begin
        case (i_avs_address)
          RTZ_IDX_RUN_CTRL:  n.rdata[7:0] = {s.active, 4'h0};
          RTZ_IDX_CONFIG:    n.rdata[7:0] = s.cfg;
          RTZ_IDX_RELOAD_HI: n.rdata[7:0] = s.rel_hi;
          RTZ_IDX_RELOAD_LO: n.rdata[7:0] = s.rel_lo;
          RTZ_IDX_COUNT_HI:  n.rdata[7:0] = s.cnt[15:8];
          RTZ_IDX_COUNT_LO:  n.rdata[7:0] = s.cnt[7:0];
          RTZ_IDX_IRQ_STAT:  n.rdata[1:0] = s.status;
          RTZ_IDX_IRQ_EN:    n.rdata[1:0] = s.enable;
          default:           n.rdata = RTZ_RST_WORD;
        endcase
      end
    end
    // Answer lasts one cycle even if the master drops early
    if (!s.wreq) begin
      n.wreq = 1'b1;
    end

    // Counting while running
    if (s.active[0] && tick) begin
      if (s.cnt != RTZ_RST_COUNT) begin
        n.cnt = s.cnt - 16'h0001;
      end else if (mode != RTZ_MODE_LFO_NU) begin
        n.und = 1'b1;
        if (s.cfg[RTZ_CFG_RESTART]) begin
          n.cnt = reload;
        end else begin
          n.active[0] = 1'b0;
        end
      end
    end

    // Hardware start at end of transmission
    if (!s.active[0] && mode == RTZ_MODE_TX_END && i_tx_done) begin
      n.active[0] = 1'b1;
      n.cnt       = reload;
    end

    // Oscillator trimming: each rising edge toggles the run state
    if (lfo_mode && i_lfo_edge) begin
      if (s.active[0]) begin
        n.active[0] = 1'b0;
      end else begin
        n.active[0] = 1'b1;
        n.cnt       = reload;
      end
    end

    if (rx_halt) begin
      n.active[0] = 1'b0;
    end

    // Software writes here win over hardware run events of the same cycle
    if (ack_wr) begin
      case (i_avs_address)
        RTZ_IDX_RUN_CTRL: begin
          for (int i = 0; i < RTZ_TIMERS; i++) begin
            if (i_avs_writedata[RTZ_MASK_LSB + i]) begin
              n.active[i] = i_avs_writedata[RTZ_RUN_LSB + i];
            end
          end
          if (i_avs_writedata[RTZ_MASK_LSB] &&
              i_avs_writedata[RTZ_RUN_LSB]) begin
            n.cnt = reload;
          end
        end
        RTZ_IDX_CONFIG:    n.cfg = i_avs_writedata[7:0] & RTZ_CFG_WMASK;
        RTZ_IDX_RELOAD_HI: n.rel_hi = i_avs_writedata[7:0];
        RTZ_IDX_RELOAD_LO: n.rel_lo = i_avs_writedata[7:0];
        RTZ_IDX_IRQ_EN:    n.enable = i_avs_writedata[1:0];
        default:           n.enable = s.enable;
      endcase
    end

    // Sticky status: set wins over clear
    n.status = s.status;
    if (ack_wr && i_avs_address == RTZ_IDX_IRQ_CLEAR) begin
      n.status = s.status & ~i_avs_writedata[1:0];
    end
    n.status[RTZ_IRQ_UNDERFLOW] = n.status[RTZ_IRQ_UNDERFLOW] | n.und;
    n.status[RTZ_IRQ_RX_HALT]   = n.status[RTZ_IRQ_RX_HALT] | rx_halt;
    n.irq = |(n.status & n.enable);
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s.wreq   <= 1'b1;
      s.rdata  <= RTZ_RST_WORD;
      s.active <= 4'h0;
      s.cfg    <= RTZ_RST_BYTE;
      s.rel_hi <= RTZ_RST_BYTE;
      s.rel_lo <= RTZ_RST_BYTE;
      s.cnt    <= RTZ_RST_COUNT;
      s.status <= 2'h0;
      s.enable <= 2'h0;
      s.irq    <= 1'b0;
      s.und    <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign o_avs_readdata         = s.rdata;
  assign o_avs_waitrequest      = s.wreq;
  assign o_timer_active         = s.active;
  assign o_timer_zero_underflow = s.und;
  assign o_irq                  = s.irq;

  // Checks
  logic hw_quiet;
  logic cnt_idle;
  assign hw_quiet = ~sw_run_wr & ~(lfo_mode & i_lfo_edge) & ~rx_halt;
  assign cnt_idle = ~tick & ~(lfo_mode & i_lfo_edge);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  mask_set_a: assert property (
    sw_run_wr && i_avs_writedata[1]
    |=> o_timer_active[1] == $past(i_avs_writedata[5]))
    else $error("masked run bit not applied");

  mask_hold_a: assert property (
    sw_run_wr && !i_avs_writedata[2] |=> $stable(o_timer_active[2]))
    else $error("unmasked run bit changed");

  run_readback_a: assert property (
    take && i_avs_read && i_avs_address == RTZ_IDX_RUN_CTRL
    |=> o_avs_readdata[7:5] == $past(o_timer_active[3:1])
        && o_avs_readdata[3:0] == 4'h0 && !o_avs_waitrequest)
    else $error("run control readback wrong");

  rx_halt_a: assert property (
    rx_halt && !sw_run_wr |=> !o_timer_active[0])
    else $error("timer not halted on receive");

  tx_start_a: assert property (
    !s.active[0] && mode == RTZ_MODE_TX_END && i_tx_done && !sw_run_wr
    |=> o_timer_active[0] && s.cnt == $past(reload))
    else $error("auto start at tx end failed");

  restart_a: assert property (
    s.active[0] && tick && s.cnt == 16'h0000 && s.cfg[RTZ_CFG_RESTART]
    && mode != RTZ_MODE_LFO_NU && hw_quiet
    |=> o_timer_active[0] && s.cnt == $past(reload)
        && o_timer_zero_underflow)
    else $error("auto restart failed");

  stop_zero_a: assert property (
    s.active[0] && tick && s.cnt == 16'h0000 && !s.cfg[RTZ_CFG_RESTART]
    && mode != RTZ_MODE_LFO_NU && hw_quiet
    |=> !o_timer_active[0])
    else $error("timer not stopped at zero");

  irq_flag_a: assert property (
    o_timer_zero_underflow
    |-> s.status[RTZ_IRQ_UNDERFLOW]
        && (!s.enable[RTZ_IRQ_UNDERFLOW] || o_irq))
    else $error("underflow flag not set");

  decrement_a: assert property (
    s.active[0] && tick && s.cnt != 16'h0000 && hw_quiet
    |=> s.cnt == $past(s.cnt) - 16'h0001)
    else $error("count did not decrement");

  reload_hold_a: assert property (
    ack_wr && s.active[0] && cnt_idle && !rx_halt
    && (i_avs_address == RTZ_IDX_RELOAD_HI
        || i_avs_address == RTZ_IDX_RELOAD_LO)
    |=> $stable(s.cnt) && o_timer_active[0])
    else $error("reload write disturbed count");

  lfo_nu_a: assert property (
    s.active[0] && tick && s.cnt == 16'h0000
    && mode == RTZ_MODE_LFO_NU |=> !o_timer_zero_underflow)
    else $error("underflow in no-underflow trimming");

  bus_answer_a: assert property (
    take |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  // Register access
  read_hold_a: assert property (
    ack_rd |=> $stable(o_avs_readdata))
    else $error("read data changed after answer");

  count_read_a: assert property (
    take && i_avs_read && i_avs_address == RTZ_IDX_COUNT_HI
    |=> o_avs_readdata == {24'h000000, $past(s.cnt[15:8])})
    else $error("count high byte readback wrong");

  reload_write_a: assert property (
    ack_wr && i_avs_address == RTZ_IDX_RELOAD_LO
    |=> s.rel_lo == $past(i_avs_writedata[7:0]))
    else $error("reload low byte not written");

  cfg_write_a: assert property (
    ack_wr && i_avs_address == RTZ_IDX_CONFIG
    |=> s.cfg == ($past(i_avs_writedata[7:0]) & RTZ_CFG_WMASK))
    else $error("config byte not written");

  // Run control
  mask_start_a: assert property (
    sw_run_wr && i_avs_writedata[RTZ_MASK_LSB]
    && i_avs_writedata[RTZ_RUN_LSB]
    |=> o_timer_active[0] && s.cnt == $past(reload))
    else $error("masked start did not load reload");

  mask_stop_a: assert property (
    sw_run_wr && i_avs_writedata[RTZ_MASK_LSB]
    && !i_avs_writedata[RTZ_RUN_LSB] |=> !o_timer_active[0])
    else $error("masked stop did not halt timer");

  others_hold_a: assert property (
    !sw_run_wr |=> $stable(o_timer_active[3:1]))
    else $error("idle timer bit changed");

  upper_only_a: assert property (
    sw_run_wr && i_avs_writedata[3:0] == 4'h0
    |=> $stable(o_timer_active[3:1]))
    else $error("write without mask changed timers");

  // Hardware start and stop
  rx_keep_a: assert property (
    i_rx_first_bits && s.active[0] && cnt_idle && !sw_run_wr
    && (lfo_mode || !s.cfg[RTZ_CFG_STOP_RX])
    |=> o_timer_active[0])
    else $error("timer halted although stop is off");

  tx_ignore_a: assert property (
    i_tx_done && !s.active[0] && mode != RTZ_MODE_TX_END
    && !lfo_mode && !sw_run_wr |=> !o_timer_active[0])
    else $error("timer started in wrong start mode");

  lfo_start_a: assert property (
    lfo_mode && i_lfo_edge && !s.active[0] && !sw_run_wr
    |=> o_timer_active[0] && s.cnt == $past(reload))
    else $error("trimming edge did not start timer");

  lfo_stop_a: assert property (
    lfo_mode && i_lfo_edge && s.active[0] && !sw_run_wr
    |=> !o_timer_active[0])
    else $error("trimming edge did not stop timer");

  lfo_hold_a: assert property (
    s.active[0] && tick && s.cnt == 16'h0000
    && mode == RTZ_MODE_LFO_NU && hw_quiet
    |=> o_timer_active[0] && s.cnt == 16'h0000)
    else $error("no-underflow trimming left zero");

  // Counting
  clk_ignore_a: assert property (
    s.active[0] && !tick && hw_quiet
    |=> o_timer_active[0] && $stable(s.cnt) && !o_timer_zero_underflow)
    else $error("count moved without selected tick");

  stopped_hold_a: assert property (
    !s.active[0] && !sw_run_wr && !(lfo_mode && i_lfo_edge)
    && !(mode == RTZ_MODE_TX_END && i_tx_done)
    |=> !o_timer_active[0] && $stable(s.cnt))
    else $error("stopped timer changed");

  und_source_a: assert property (
    o_timer_zero_underflow
    |-> $past(s.active[0]) && $past(tick) && $past(s.cnt) == 16'h0000
        && $past(mode) != RTZ_MODE_LFO_NU)
    else $error("underflow without zero tick");

  // Interrupt
  status_hold_a: assert property (
    s.status[RTZ_IRQ_UNDERFLOW]
    && !(ack_wr && i_avs_address == RTZ_IDX_IRQ_CLEAR)
    |=> s.status[RTZ_IRQ_UNDERFLOW])
    else $error("underflow flag lost");

  irq_level_a: assert property (
    o_irq == |(s.status & s.enable))
    else $error("interrupt level wrong");

  restart_c: cover property (
    o_timer_zero_underflow && o_timer_active[0]);
  tx_start_c: cover property (
    mode == RTZ_MODE_TX_END && i_tx_done ##1 o_timer_active[0]);
  rx_halt_c: cover property (rx_halt);
  irq_c: cover property (o_irq);
  lfo_c: cover property (lfo_mode && i_lfo_edge && s.active[0]);
endmodule

// File: tb/rtz_timer_zero_tb.sv
// Self-checking bench for the timer zero control block
`timescale 1ns/1ns
module rtz_timer_zero_tb;
  import rtz_pkg::*;
  logic        clock;
  logic        reset_n;
  logic [5:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        waitreq;
  logic        uf;
  logic        irq;
  logic [6:0]  ev;
  logic [3:0]  act;
  logic [3:0]  be;
  int          bad_count;
  int          check_count;
  int          uf_seen;
  int          uf_exp;
  int          m_act;
  int          m_cfg;
  int          m_rel;
  int          m_cnt;
  int          m_stat;
  int          m_en;

  rtz_timer_zero dut (
    .i_clock               (clock),
    .i_reset_n             (reset_n),
    .i_avs_address         (addr),
    .i_avs_read            (rd),
    .i_avs_write           (wr),
    .i_avs_writedata       (wdata),
    .i_avs_byteenable      (be),
    .o_avs_readdata        (rdata),
    .o_avs_waitrequest     (waitreq),
    .i_tick_carrier        (ev[0]),
    .i_tick_divided        (ev[1]),
    .i_timer_two_underflow (ev[2]),
    .i_timer_one_underflow (ev[3]),
    .i_tx_done             (ev[4]),
    .i_rx_first_bits       (ev[5]),
    .i_lfo_edge            (ev[6]),
    .o_timer_active        (act),
    .o_timer_zero_underflow(uf),
    .o_irq                 (irq)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Counted mid-cycle, clear of edge races
  always @(negedge clock) if (uf === 1'b1) uf_seen++;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clock);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) check("waitrequest", 32'h1, 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [31:0] mreg(input logic [5:0] a);
    case (a)
      6'h0E:   return (m_act & 15) << 4;
      6'h0F:   return m_cfg;
      6'h10:   return m_rel >> 8;
      6'h11:   return m_rel & 255;
      6'h12:   return m_cnt >> 8;
      6'h13:   return m_cnt & 255;
      6'h20:   return m_stat;
      6'h22:   return m_en;
      default: return 0;
    endcase
  endfunction

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    case (a)
      6'h0E: for (int i = 0; i < 4; i++) if (d[i]) begin
        m_act[i] = d[4+i];
        if (i == 0 && d[4]) m_cnt = m_rel;
      end
      6'h0F: m_cfg = d & 8'hBB;
      6'h10: m_rel = {d, m_rel[7:0]};
      6'h11: m_rel = {m_rel[15:8], d};
      6'h21: m_stat = m_stat & ~int'(d);
      6'h22: m_en = d & 8'h03;
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [5:0] a);
    bus(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), q, mreg(a));
  endtask

  task automatic chk_out;
    check("active", {28'h0, act}, m_act & 15);
    check("irq", {31'h0, irq}, (m_stat & m_en) != 0);
    check("underflows", uf_seen, uf_exp);
  endtask

  function automatic void mstep(input int b);
    int md;
    md = (m_cfg >> 4) & 3;
    if (b < 4 && b == (m_cfg & 3) && m_act[0]) begin
      if (m_cnt != 0) m_cnt--;
      else if (md != 2) begin
        m_stat |= 1;
        uf_exp++;
        if (m_cfg[3]) m_cnt = m_rel;
        else m_act[0] = 0;
      end
    end
    if (b == 4 && md == 1 && !m_act[0]) begin
      m_act[0] = 1;
      m_cnt = m_rel;
    end
    if (b == 6 && md >= 2) begin
      m_act[0] = !m_act[0];
      if (m_act[0]) m_cnt = m_rel;
    end
    if (b == 5 && md < 2 && m_cfg[7] && m_act[0]) begin
      m_act[0] = 0;
      m_stat |= 2;
    end
  endfunction

  task automatic pulse(input int b);
    mstep(b);
    ev <= 7'h01 << b;
    @(posedge clock);
    ev <= 7'h00;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    logic [5:0] al [10];
    logic [7:0] ml [4];
    al = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20, 6'h21, 6'h22,
           6'h3F};
    ml = '{8'h10, 8'h90, 8'hA0, 8'hB0};
    {addr, rd, wr, wdata, ev, reset_n} = '0;
    be = 4'hF;
    {m_act, m_cfg, m_rel, m_cnt, m_stat, m_en, uf_exp} = '0;
    void'($urandom(34954));
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (al[i]) rd_chk(al[i]);
    wr_reg(6'h0F, 8'hFF);
    rd_chk(6'h0F);
    // Write with byte lane 0 disabled must be ignored
    be <= 4'hE;
    bus(1'b1, 6'h0F, 8'h00);
    be <= 4'hF;
    rd_chk(6'h0F);
    foreach (ml[i]) begin
      wr_reg(6'h0E, {ml[i][7:4], 4'hF} ^ 8'h0F ^ {4'h0, ml[i][7:4]});
    end
    for (int d = 0; d < 4; d++) begin
      wr_reg(6'h0E, d == 0 ? 8'hF0 : d == 1 ? 8'hFF : d == 2 ? 8'h0A : 8'h0F);
      chk_out;
      rd_chk(6'h0E);
    end
    wr_reg(6'h22, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wr_reg(6'h0F, s);
      wr_reg(6'h10, 8'h00);
      wr_reg(6'h11, $urandom_range(1, 4));
      wr_reg(6'h0E, 8'h11);
      for (int b = 0; b < 4; b++) if (b != s) pulse(b);
      repeat (m_rel + 1) begin
        pulse(s);
        if (m_act[0]) rd_chk(6'h13);
      end
      chk_out;
      wr_reg(6'h21, 8'h01);
      chk_out;
    end
    wr_reg(6'h0F, 8'h08);
    wr_reg(6'h10, $urandom);
    wr_reg(6'h11, $urandom);
    wr_reg(6'h0E, 8'h11);
    wr_reg(6'h10, $urandom);
    repeat (2) pulse(0);
    rd_chk(6'h12);
    rd_chk(6'h13);
    wr_reg(6'h10, 8'h00);
    wr_reg(6'h11, 8'h01);
    wr_reg(6'h0E, 8'h11);
    repeat (5) pulse(0);
    chk_out;
    foreach (ml[i]) begin
      wr_reg(6'h0E, 8'h01);
      wr_reg(6'h0F, ml[i]);
      for (int b = 4; b < 7; b++) pulse(b);
      repeat (3) pulse(0);
      rd_chk(6'h20);
      pulse(6);
      chk_out;
    end
    repeat (300) begin
      case ($urandom_range(0, 9))
        0: wr_reg(6'h0F, $urandom);
        1: wr_reg(6'h0E, $urandom);
        2: wr_reg(6'h11, $urandom_range(0, 3));
        3: wr_reg(6'h21, $urandom);
        default: ;
      endcase
      pulse($urandom_range(0, 6));
      chk_out;
      if (m_act[0]) rd_chk(6'h13);
    end
    // Reset in mid-run returns every register to zero
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    {m_act, m_cfg, m_rel, m_cnt, m_stat, m_en} = '0;
    reset_n <= 1'b1;
    @(posedge clock);
    chk_out;
    foreach (al[i]) rd_chk(al[i]);
    report_and_stop;
  end

  initial begin
    #400000;
    bad_count++;
    report_and_stop;
  end
endmodule
